// ---- prsc_ctrl.sv ----
`timescale 1ns/100ps
module prsc_ctrl
  import prsc_pkg::*;
#(
  parameter int NOMINAL_PERIOD = 160,
  parameter int TRI_SPAN_UNIT = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Device state and timing pins
  input wire logic i_output_active,
  input wire logic i_phase_sync,
  input wire logic i_frame_sync,
  // Ramp outputs
  output logic o_ramp_tick,
  output logic [PRSC_CW-1:0] o_ramp_count,
  output logic [PRSC_CW-1:0] o_ramp_period,
  output logic [1:0] o_active_phase
);
  localparam logic [PRSC_CW-1:0] NOM = PRSC_CW'(NOMINAL_PERIOD);

  logic [7:0] phase_q, mode_q, range_q, div_q, step_q;
  logic [1:0] phase_used_q;
  logic [2:0] psync_q, fsync_q;
  logic half_en_q;
  logic [PRSC_CW-1:0] cnt_q, per_q, tri_q;
  logic tri_down_q;
  logic [15:0] rnd;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      phase_q <= PRSC_RST_PHASE;
      mode_q <= PRSC_RST_MODE;
      range_q <= PRSC_RST_RANGE;
      div_q <= PRSC_RST_DIV;
      step_q <= PRSC_RST_STEP;
    end else if (i_reg_wr) begin
      // Reserved bits are stored and read back but steer nothing
      case (i_reg_addr)
        PRSC_OFS_PHASE: phase_q <= i_reg_wdata;
        PRSC_OFS_MODE: mode_q <= i_reg_wdata;
        PRSC_OFS_RANGE: range_q <= i_reg_wdata;
        PRSC_OFS_DIV: div_q <= i_reg_wdata;
        PRSC_OFS_STEP: step_q <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (i_reg_addr)
      PRSC_OFS_PHASE: o_reg_rdata = phase_q;
      PRSC_OFS_MODE: o_reg_rdata = mode_q;
      PRSC_OFS_RANGE: o_reg_rdata = range_q;
      PRSC_OFS_DIV: o_reg_rdata = div_q;
      PRSC_OFS_STEP: o_reg_rdata = step_q;
      default: o_reg_rdata = 8'h00;
    endcase
  end

  wire lock_on = phase_q[PRSC_B_LOCK];
  wire align_on = phase_q[PRSC_B_FRAME_ALIGN];
  wire tri_on = mode_q[PRSC_B_TRI_ON];
  wire rdm_on = mode_q[PRSC_B_RDM_ON];
  wire hand = mode_q[PRSC_B_HAND];
  wire halve = mode_q[PRSC_B_HALVE];
  wire [2:0] rdm_rng = range_q[PRSC_B_RDM_LO +: 3];
  wire [3:0] tri_set = range_q[PRSC_B_TRI_LO +: 4];
  wire [3:0] fall_inc = step_q[PRSC_B_FALL_LO +: 4];
  wire [3:0] rise_inc = step_q[PRSC_B_RISE_LO +: 4];

  ////////////////////////////////////////////////////////////////////////////
  // Phase choice is frozen while the output stage is active, so a late
  // write cannot make the carrier jump mid-play

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      phase_used_q <= 2'h0;
    end else if (!i_output_active) begin
      phase_used_q <= phase_q[PRSC_B_PHASE_LO +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; bit 0 is the metastable stage

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      psync_q <= 3'h0;
      fsync_q <= 3'h0;
    end else begin
      psync_q <= {psync_q[1:0], i_phase_sync};
      fsync_q <= {fsync_q[1:0], i_frame_sync};
    end
  end

  wire psync_rise = psync_q[1] & ~psync_q[2];
  wire fsync_rise = fsync_q[1] & ~fsync_q[2];
  wire restart = (lock_on & psync_rise) | (align_on & fsync_rise);

  ////////////////////////////////////////////////////////////////////////////
  // Source clock enable: every cycle, or every other in halved manual mode

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      half_en_q <= 1'b0;
    end else begin
      half_en_q <= ~half_en_q;
    end
  end

  wire src_en = !(hand && halve) || half_en_q;

  ////////////////////////////////////////////////////////////////////////////
  // Spread offsets

  // Base period counts source clocks: 61.44 MHz / N in manual mode
  wire [PRSC_CW-1:0] base = hand ? PRSC_CW'(div_q) : NOM;
  wire [3:0] up_step = hand ? rise_inc
                            : {2'b00, tri_set[1:0]} + 4'h1;
  wire [3:0] dn_step = hand ? fall_inc
                            : {2'b00, tri_set[1:0]} + 4'h1;
  wire [PRSC_CW-1:0] tri_lim =
    PRSC_CW'(({2'b00, tri_set[3:2]} + 4'h1) * TRI_SPAN_UNIT);
  wire [6:0] rdm_mask = 7'((8'h01 << rdm_rng) - 8'h01);
  wire [PRSC_CW-1:0] rdm_ofs =
    rdm_on ? PRSC_CW'(rnd[6:0] & rdm_mask) : '0;
  wire [PRSC_CW-1:0] tri_ofs = tri_on ? tri_q : '0;

  wire wrap = src_en && (cnt_q >= per_q - PRSC_CW'(1));

  prsc_lfsr #(
    .W(16)
  ) u_lfsr (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_step(wrap),
    .o_value(rnd)
  );

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !tri_on) begin
      tri_q <= '0;
      tri_down_q <= 1'b0;
    end else if (wrap) begin
      if (!tri_down_q) begin
        if (tri_q + PRSC_CW'(up_step) >= tri_lim) begin
          tri_q <= tri_lim;
          tri_down_q <= 1'b1;
        end else begin
          tri_q <= tri_q + PRSC_CW'(up_step);
        end
      end else begin
        if (tri_q <= PRSC_CW'(dn_step)) begin
          tri_q <= '0;
          tri_down_q <= 1'b0;
        end else begin
          tri_q <= tri_q - PRSC_CW'(dn_step);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ramp counter; period is only reloaded at a wrap so a ramp never tears

  // A period of zero would wrap the compare to 4095 and run a 4096-count ramp, so treat it as one
  wire [PRSC_CW-1:0] next_per_raw = base + tri_ofs + rdm_ofs;
  wire [PRSC_CW-1:0] next_per =
    (next_per_raw == '0) ? PRSC_CW'(1) : next_per_raw;
  wire [PRSC_CW+1:0] ofs_prod = per_q * phase_used_q;
  wire [PRSC_CW-1:0] phase_ofs = ofs_prod[PRSC_CW+1:2];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_q <= '0;
      per_q <= NOM;
      o_ramp_tick <= 1'b0;
    end else begin
      o_ramp_tick <= wrap;
      if (restart) begin
        cnt_q <= phase_ofs;
      end else if (wrap) begin
        cnt_q <= '0;
        per_q <= next_per;
      end else if (src_en) begin
        cnt_q <= cnt_q + PRSC_CW'(1);
      end
    end
  end

  // Free-running ramps start from zero on leaving reset and take the phase
  // only through restart; without sync the offset is relative to nothing.
  assign o_ramp_count = cnt_q;
  assign o_ramp_period = per_q;
  assign o_active_phase = phase_used_q;
endmodule

// ---- prsc_pkg.sv ----
package prsc_pkg;
  // Register offsets
  localparam logic [7:0] PRSC_OFS_PHASE = 8'h6a;
  localparam logic [7:0] PRSC_OFS_MODE = 8'h6b;
  localparam logic [7:0] PRSC_OFS_RANGE = 8'h6c;
  localparam logic [7:0] PRSC_OFS_DIV = 8'h6d;
  localparam logic [7:0] PRSC_OFS_STEP = 8'h6e;
  // Reset values
  localparam logic [7:0] PRSC_RST_PHASE = 8'h00;
  localparam logic [7:0] PRSC_RST_MODE = 8'h00;
  localparam logic [7:0] PRSC_RST_RANGE = 8'h00;
  localparam logic [7:0] PRSC_RST_DIV = 8'h50;
  localparam logic [7:0] PRSC_RST_STEP = 8'h11;
  // Field positions: ramp_phase_setup
  localparam int PRSC_B_LOCK = 0;
  localparam int PRSC_B_FRAME_ALIGN = 1;
  localparam int PRSC_B_PHASE_LO = 2;
  // Field positions: spread_mode_setup
  localparam int PRSC_B_TRI_ON = 0;
  localparam int PRSC_B_RDM_ON = 1;
  localparam int PRSC_B_HAND = 4;
  localparam int PRSC_B_HALVE = 5;
  // Field positions: spread_range_setup, triangle_step_setup
  localparam int PRSC_B_RDM_LO = 4;
  localparam int PRSC_B_TRI_LO = 0;
  localparam int PRSC_B_FALL_LO = 4;
  localparam int PRSC_B_RISE_LO = 0;
  // Manual-mode ramp frequency numerator, Hz
  localparam int PRSC_MANUAL_NUM_HZ = 61440000;
  // Period counter width
  localparam int PRSC_CW = 12;
  // Random seed, arbitrary nonzero
  localparam logic [15:0] PRSC_LFSR_SEED = 16'hace1;
endpackage

// ---- prsc_lfsr.sv ----
`timescale 1ns/100ps
module prsc_lfsr
  import prsc_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Advance strobe and state
  input wire logic i_step,
  output logic [W-1:0] o_value
);
  logic [W-1:0] lfsr_q;
  logic fb;

  // Taps 16,15,13,4 give a maximal sequence
  assign fb = lfsr_q[W-1] ^ lfsr_q[W-2] ^ lfsr_q[W-4] ^ lfsr_q[3];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lfsr_q <= PRSC_LFSR_SEED[W-1:0];
    end else if (i_step) begin
      lfsr_q <= {lfsr_q[W-2:0], fb};
    end
  end

  assign o_value = lfsr_q;
endmodule

// ---- prsc_ctrl_assertions.sv ----
`timescale 1ns/100ps
module prsc_ctrl_assertions
  import prsc_pkg::*;
#(
  parameter int NOMINAL_PERIOD = 160
) (
  // Clock, reset, registers
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  // Pins and ramp
  input wire logic i_output_active,
  input wire logic i_phase_sync,
  input wire logic i_frame_sync,
  input wire logic o_ramp_tick,
  input wire logic [PRSC_CW-1:0] o_ramp_count,
  input wire logic [PRSC_CW-1:0] o_ramp_period,
  input wire logic [1:0] o_active_phase
);
  logic [7:0] ph_q;
  logic [7:0] mode_q;
  logic [7:0] div_q;
  wire logic hit = i_reg_addr inside {[PRSC_OFS_PHASE:PRSC_OFS_STEP]};
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // Shadows tell the checks which mode is in force
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ph_q <= PRSC_RST_PHASE;
      mode_q <= PRSC_RST_MODE;
      div_q <= PRSC_RST_DIV;
    end else if (i_reg_wr) begin
      if (i_reg_addr == PRSC_OFS_PHASE) ph_q <= i_reg_wdata;
      if (i_reg_addr == PRSC_OFS_MODE) mode_q <= i_reg_wdata;
      if (i_reg_addr == PRSC_OFS_DIV) div_q <= i_reg_wdata;
    end
  end
  sequence reg_wr_s;
    i_reg_wr && hit ##1 $stable(i_reg_addr);
  endsequence
  sequence sync_rise_s;
    ph_q[0] && $rose(i_phase_sync) || ph_q[1] && $rose(i_frame_sync);
  endsequence
  reset_state_a: assert property ($past(i_sys_rst) |->
    o_ramp_count == '0 && o_ramp_period == NOMINAL_PERIOD)
    else $error("ramp state wrong after reset");
  reg_echo_a: assert property (reg_wr_s |->
    o_reg_rdata == $past(i_reg_wdata)) else $error("write not stored");
  unmapped_zero_a: assert property (!hit |->
    o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  tick_wrap_a: assert property (o_ramp_tick |->
    $past(o_ramp_count) >= $past(o_ramp_period) - 12'h001)
    else $error("tick without wrap");
  nominal_rate_a: assert property (o_ramp_tick &&
    ($past(mode_q) & 8'h13) == 8'h00 |-> o_ramp_period == NOMINAL_PERIOD)
    else $error("nominal period wrong");
  manual_period_a: assert property (o_ramp_tick &&
    ($past(mode_q) & 8'h13) == 8'h10 && $past(div_q) != 8'h00
    |-> o_ramp_period == {4'h0, $past(div_q)})
    else $error("manual period wrong");
  halve_rate_a: assert property (mode_q[5:4] == 2'b11 &&
    ($past(mode_q) & 8'h30) == 8'h30 && ph_q[1:0] == 2'b00 &&
    $changed(o_ramp_count) |=> $stable(o_ramp_count))
    else $error("halved source runs too fast");
  sync_restart_a: assert property (sync_rise_s |-> ##[1:4]
    o_ramp_count == 12'((14'(o_ramp_period) * o_active_phase) >> 2))
    else $error("no phase restart");
  phase_hold_a: assert property (i_output_active &&
    $past(i_output_active) |-> $stable(o_active_phase))
    else $error("phase changed while active");
endmodule
bind prsc_ctrl prsc_ctrl_assertions #(.NOMINAL_PERIOD(NOMINAL_PERIOD))
  prsc_ctrl_assertions_inst (.i_clk, .i_sys_rst, .i_reg_addr, .i_reg_wr,
  .i_reg_wdata, .o_reg_rdata, .i_output_active, .i_phase_sync,
  .i_frame_sync, .o_ramp_tick, .o_ramp_count, .o_ramp_period,
  .o_active_phase);

// ---- pwm_ramp_phase_spread_ctrl_test.sv ----
`timescale 1ns/100ps
module pwm_ramp_phase_spread_ctrl_test;
  import prsc_pkg::*;
  localparam logic [11:0] NP = 12'h028;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wr = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_output_active = 1'b0;
  logic i_phase_sync = 1'b0;
  logic i_frame_sync = 1'b0;
  logic [7:0] o_reg_rdata;
  logic o_ramp_tick;
  logic [PRSC_CW-1:0] o_ramp_count;
  logic [PRSC_CW-1:0] o_ramp_period;
  logic [PRSC_CW-1:0] p0;
  logic [1:0] o_active_phase;
  int miscompares = 0;
  int compares = 0;
  always #4 i_clk = ~i_clk;
  prsc_ctrl #(.NOMINAL_PERIOD(NP)) prsc_ctrl_inst (.i_clk, .i_sys_rst,
    .i_reg_addr, .i_reg_wr, .i_reg_wdata, .o_reg_rdata, .i_output_active,
    .i_phase_sync, .i_frame_sync, .o_ramp_tick, .o_ramp_count,
    .o_ramp_period, .o_active_phase);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rst_pulse;
    @(posedge i_clk) i_sys_rst <= 1'b1;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk) i_reg_addr <= a;
    @(negedge i_clk) chk(12'(o_reg_rdata), 12'(exp));
  endtask
  // Cycles to the next tick; bounded so a dead ramp cannot hang
  task automatic tick(output int n);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_ramp_tick !== 1'b1 && n < 4000);
    // A ramp that never ticks is a failure, not just a slow test
    if (o_ramp_tick !== 1'b1) miscompares++;
  endtask
  task automatic pulse(input logic fr);
    @(posedge i_clk);
    if (fr) i_frame_sync <= 1'b1;
    else i_phase_sync <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_frame_sync <= 1'b0;
    i_phase_sync <= 1'b0;
    @(negedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int seen;
    rst_pulse();
    rc(PRSC_OFS_PHASE, PRSC_RST_PHASE);
    rc(PRSC_OFS_MODE, PRSC_RST_MODE);
    rc(PRSC_OFS_RANGE, PRSC_RST_RANGE);
    rc(PRSC_OFS_DIV, PRSC_RST_DIV);
    rc(PRSC_OFS_STEP, PRSC_RST_STEP);
    for (int i = 0; i < 5; i++) wr(PRSC_OFS_PHASE + 8'(i), 8'hc3 ^ 8'(i));
    for (int i = 0; i < 5; i++) rc(PRSC_OFS_PHASE + 8'(i), 8'hc3 ^ 8'(i));
    wr(8'h6f, 8'hff);
    rc(8'h6f, 8'h00);
    rst_pulse();
    tick(n);
    tick(n);
    chk(12'(n), NP);
    wr(PRSC_OFS_RANGE, 8'h30);
    wr(PRSC_OFS_MODE, 8'h02);
    // Dither must stay inside its span and must actually move the period
    seen = 0;
    repeat (6) begin
      tick(n);
      chk(12'(o_ramp_period - NP < 12'h008), 12'h001);
      if (o_ramp_period != NP) seen = 1;
    end
    chk(12'(seen), 12'h001);
    rst_pulse();
    wr(PRSC_OFS_RANGE, 8'h03);
    wr(PRSC_OFS_MODE, 8'h01);
    tick(n);
    p0 = o_ramp_period;
    tick(n);
    chk(o_ramp_period - p0, 12'h004);
    rst_pulse();
    wr(PRSC_OFS_DIV, 8'h14);
    wr(PRSC_OFS_MODE, 8'h10);
    tick(n);
    chk(o_ramp_period, 12'h014);
    tick(n);
    chk(12'(n), 12'h014);
    wr(PRSC_OFS_MODE, 8'h30);
    tick(n);
    tick(n);
    chk(12'(n), 12'h028);
    wr(PRSC_OFS_STEP, 8'h32);
    wr(PRSC_OFS_MODE, 8'h11);
    tick(n);
    p0 = o_ramp_period;
    tick(n);
    chk(o_ramp_period - p0, 12'h002);
    seen = 0;
    repeat (8) begin
      p0 = o_ramp_period;
      tick(n);
      if (p0 - o_ramp_period == 12'h003) seen = 1;
    end
    chk(12'(seen), 12'h001);
    // Phase is set while idle; spread settings stay as they are
    wr(PRSC_OFS_PHASE, 8'h09);
    pulse(1'b0);
    chk(12'(o_active_phase), 12'h002);
    // Restart lands two syncing edges after the pin, then three increments
    chk(o_ramp_count, (o_ramp_period >> 1) + 12'h003);
    @(posedge i_clk) i_output_active <= 1'b1;
    wr(PRSC_OFS_PHASE, 8'h0d);
    pulse(1'b0);
    chk(12'(o_active_phase), 12'h002);
    chk(o_ramp_count, (o_ramp_period >> 1) + 12'h003);
    @(posedge i_clk) i_output_active <= 1'b0;
    wr(PRSC_OFS_PHASE, 8'h0e);
    pulse(1'b1);
    chk(12'(o_active_phase), 12'h003);
    chk(o_ramp_count, 12'((o_ramp_period * 3) >> 2) + 12'h003);
    conclude();
  end
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
endmodule
